// ---- hw/adccm_regs.sv ----
// Converter configuration and chip mode registers with conversion sequencing.
`timescale 1ns/100ps

// Behaviour
// - Bits 7:6 of rate register select sampling frequency, reset zero.
// - Bits 5:1 of mux register select the input channel, reset zero.
// - Mux bit 0 picks reference: zero supply voltage, one reference input.
// - Writing one to mux bit 6 loads defaults into all but the mode register and starts a conversion.
// - Mode bits 5:4 chop: hold 0, hold 1, toggle each, toggle every two.
// - Mode bit 3 forces the charge pump on, winning over force-off.
// - Mode bit 2 forces pump off; resets to one.
// - Mode bit 1 routes internal reference onto digital pin a.
// - Mode bit 0 takes external reference from digital pin b.
// - Mux bit 7 is read-only busy; mode bit 7 reads one, bit 6 zero.
// - Elementary count is two to the cfg0 bits 6:5; input chop alternates.
// - Writing one to cfg0 bit 7 starts a conversion.
module adccm_regs
    import adccm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire adccm_req_t regReq,
    output logic [7:0]      regRdData,
    input  wire logic       elemDone,
    input  wire logic       supplyLow,
    output logic [1:0]      sample_rate_select,
    output logic [1:0]      second_stage_gain_select,
    output logic [3:0]      second_stage_offset_select,
    output logic            first_stage_gain_select,
    output logic [6:0]      third_stage_gain_select,
    output logic [6:0]      third_stage_offset_select,
    output logic [4:0]      inputChannelSel,
    output logic            referenceSel,
    output logic [1:0]      elementary_count_exponent,
    output logic            convStart,
    output logic            convBusy,
    output logic            resultLoad,
    output logic            inputChop,
    output logic            refChop,
    output logic            pumpOn,
    output logic            reference_out_on_pin_a,
    output logic            external_reference_on_pin_b
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]   cfg0_q, rate_q, gain_q, off3_q;
    logic [5:0]   mux_q, mode_q;
    logic [7:0]   rdData_q;
    logic         supplyMeta_q, supplySync_q;
    adccm_state_t state_q, state_d;
    logic [3:0]   elemCnt_q;
    logic         busy_q, start_q, load_q, inChop_q, refChop_q, chopHalf_q, pump_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire         wrCfg0    = regReq.wr && regReq.addr == OFS_CFG0;
    wire         wrRate    = regReq.wr && regReq.addr == OFS_RATE;
    wire         wrGain    = regReq.wr && regReq.addr == OFS_GAIN;
    wire         wrOff3    = regReq.wr && regReq.addr == OFS_OFF3;
    wire         wrMux     = regReq.wr && regReq.addr == OFS_MUX;
    wire         wrMode    = regReq.wr && regReq.addr == OFS_MODE;
    wire         loadDef   = wrMux && regReq.data[MUX_DEF_BIT];
    wire         startCmd  = loadDef || (wrCfg0 && regReq.data[CFG0_START_BIT]);
    wire [1:0]   expSel    = cfg0_q[CFG0_EXP_HI:CFG0_EXP_LO];
    wire [3:0]   elemTgt   = 4'h1 << expSel;
    wire         lastElem  = (state_q == ADCCM_CONV) && elemDone && (elemCnt_q + 4'h1 == elemTgt);
    wire         fOn       = mode_q[MODE_FON_BIT];
    wire         fOff      = mode_q[MODE_FOFF_BIT];
    wire         pump_d    = fOn || (!fOff && supplySync_q);
    wire [7:0]   cfg0Rd    = {busy_q, cfg0_q[6:1], 1'b0};
    wire [7:0]   muxRd     = {busy_q, 1'b0, mux_q[4:0], mux_q[5]};
    wire [7:0]   modeRd    = {MODE_FIXED, mode_q};
    wire [7:0]   rdMux     = (regReq.addr == OFS_CFG0) ? cfg0Rd :
                             (regReq.addr == OFS_RATE) ? rate_q :
                             (regReq.addr == OFS_GAIN) ? gain_q :
                             (regReq.addr == OFS_OFF3) ? off3_q :
                             (regReq.addr == OFS_MUX)  ? muxRd  :
                             (regReq.addr == OFS_MODE) ? modeRd : 8'h00;
    // The pair phase bit is set after the first elementary conversion of each pair.
    wire         chopEdge  = chopHalf_q;
    wire adccm_chop_t chopMode = adccm_chop_t'(mode_q[MODE_CHOP_HI:MODE_CHOP_LO]);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // The mux register keeps the reference select in bit 5 of its storage.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg0_q <= RST_CFG0;
            rate_q <= RST_RATE;
            gain_q <= RST_GAIN;
            off3_q <= RST_OFF3;
            mux_q  <= RST_MUX;
            mode_q <= RST_MODE;
        end else if (loadDef) begin
            cfg0_q <= RST_CFG0;
            rate_q <= RST_RATE;
            gain_q <= RST_GAIN;
            off3_q <= RST_OFF3;
            mux_q  <= RST_MUX;
        end else begin
            if (wrCfg0) cfg0_q <= regReq.data & CFG0_WMASK;
            if (wrRate) rate_q <= regReq.data;
            if (wrGain) gain_q <= regReq.data;
            if (wrOff3) off3_q <= regReq.data;
            if (wrMux)  mux_q  <= {regReq.data[0], regReq.data[5:1]};
            if (wrMode) mode_q <= regReq.data[5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 8'h00;
        end else if (regReq.rd) begin
            rdData_q <= rdMux;
        end
    end

    // ------------------------------------------------------------------
    // Supply level synchroniser and charge pump control
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            supplyMeta_q <= 1'b0;
            supplySync_q <= 1'b0;
            pump_q       <= 1'b0;
        end else begin
            supplyMeta_q <= supplyLow;
            supplySync_q <= supplyMeta_q;
            pump_q       <= pump_d;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ADCCM_IDLE: if (startCmd) state_d = ADCCM_CONV;
            ADCCM_CONV: if (lastElem && !startCmd) state_d = ADCCM_IDLE;
            default:    state_d = ADCCM_IDLE;
        endcase
    end

    // A start in the cycle of the last elementary conversion restarts rather than ends.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ADCCM_IDLE;
            busy_q    <= 1'b0;
            start_q   <= 1'b0;
            load_q    <= 1'b0;
            elemCnt_q <= 4'h0;
        end else begin
            state_q   <= state_d;
            busy_q    <= (state_d == ADCCM_CONV);
            start_q   <= startCmd;
            load_q    <= lastElem;
            if (startCmd || lastElem) elemCnt_q <= 4'h0;
            else if (state_q == ADCCM_CONV && elemDone) elemCnt_q <= elemCnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Chopping
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inChop_q   <= 1'b0;
            refChop_q  <= 1'b0;
            chopHalf_q <= 1'b0;
        end else if (startCmd) begin
            inChop_q   <= 1'b0;
            chopHalf_q <= 1'b0;
        end else begin
            if (state_q == ADCCM_CONV && elemDone) begin
                inChop_q <= !inChop_q;
                chopHalf_q <= !chopHalf_q;
            end
            case (chopMode)
                ADCCM_CHOP_ZERO: refChop_q <= 1'b0;
                ADCCM_CHOP_ONE:  refChop_q <= 1'b1;
                ADCCM_CHOP_EACH: if (state_q == ADCCM_CONV && elemDone) refChop_q <= !refChop_q;
                ADCCM_CHOP_PAIR: if (state_q == ADCCM_CONV && elemDone && chopEdge) refChop_q <= !refChop_q;
                default:         refChop_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdData                   = rdData_q;
    assign sample_rate_select          = rate_q[7:6];
    assign second_stage_gain_select    = rate_q[5:4];
    assign second_stage_offset_select  = rate_q[3:0];
    assign first_stage_gain_select     = gain_q[7];
    assign third_stage_gain_select     = gain_q[6:0];
    assign third_stage_offset_select   = off3_q[6:0];
    assign inputChannelSel             = mux_q[4:0];
    assign referenceSel                = mux_q[5];
    assign elementary_count_exponent   = expSel;
    assign convStart                   = start_q;
    assign convBusy                    = busy_q;
    assign resultLoad                  = load_q;
    assign inputChop                   = inChop_q;
    assign refChop                     = refChop_q;
    assign pumpOn                      = pump_q;
    assign reference_out_on_pin_a      = mode_q[MODE_REFOUT_BIT];
    assign external_reference_on_pin_b = mode_q[MODE_EXTREF_BIT];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    busy_on_start_a: assert property (startCmd |=> convBusy && convStart)
        else $error("Busy or start pulse missing after a start command.");
    def_reload_a: assert property (loadDef |=> third_stage_gain_select == 7'h0c && inputChannelSel == 5'h00)
        else $error("Default load did not restore the amplifier configuration.");
    busy_until_store_a: assert property (lastElem && !startCmd |=> resultLoad && !convBusy)
        else $error("Busy not cleared together with the result load.");
    pump_force_on_a: assert property (fOn |=> pumpOn)
        else $error("Charge pump not on while forced on.");
    pump_force_off_a: assert property (fOff && !fOn |=> !pumpOn)
        else $error("Charge pump not off while forced off.");
    mode_fixed_a: assert property (regReq.rd && regReq.addr == OFS_MODE |=> regRdData[7:6] == 2'b10)
        else $error("Mode register fixed bits read wrong.");
    chop_hold_a: assert property (!startCmd && chopMode == ADCCM_CHOP_ONE |=> refChop)
        else $error("Reference chop not held at one.");
    chop_each_a: assert property (!startCmd && chopMode == ADCCM_CHOP_EACH && state_q == ADCCM_CONV
                                  && elemDone |=> refChop != $past(refChop))
        else $error("Reference chop did not toggle on an elementary conversion.");
    elem_count_a: assert property (state_q == ADCCM_CONV && elemDone && !startCmd |=> elemCnt_q < elemTgt)
        else $error("Elementary conversion count ran past its target.");
    rate_write_a: assert property (wrRate && !loadDef |=> sample_rate_select == $past(regReq.data[7:6]))
        else $error("Sampling frequency select not written.");

    conv_done_c:  cover property (startCmd ##[1:40] resultLoad);
    def_start_c:  cover property (loadDef ##1 convBusy);
    chop_pair_c:  cover property (chopMode == ADCCM_CHOP_PAIR && elemDone && chopEdge);
    pump_auto_c:  cover property (!fOn && !fOff && pumpOn);

endmodule

// ---- hw/adccm_pkg.sv ----
// Package with register map, reset values and shared types of the converter configuration block.
package adccm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CFG0 = 8'h52;
    localparam logic [7:0] OFS_RATE = 8'h54;
    localparam logic [7:0] OFS_GAIN = 8'h55;
    localparam logic [7:0] OFS_OFF3 = 8'h56;
    localparam logic [7:0] OFS_MUX  = 8'h57;
    localparam logic [7:0] OFS_MODE = 8'h70;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG0_START_BIT  = 7;
    localparam int CFG0_EXP_HI     = 6;
    localparam int CFG0_EXP_LO     = 5;
    localparam int MUX_BUSY_BIT    = 7;
    localparam int MUX_DEF_BIT     = 6;
    localparam int MODE_CHOP_HI    = 5;
    localparam int MODE_CHOP_LO    = 4;
    localparam int MODE_FON_BIT    = 3;
    localparam int MODE_FOFF_BIT   = 2;
    localparam int MODE_REFOUT_BIT = 1;
    localparam int MODE_EXTREF_BIT = 0;

    // ------------------------------------------------------------------
    // Values after reset, write mask and fixed read bits
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CFG0 = 8'h28;
    localparam logic [7:0] RST_RATE = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h0c;
    localparam logic [7:0] RST_OFF3 = 8'h00;
    localparam logic [5:0] RST_MUX  = 6'h00;
    localparam logic [5:0] RST_MODE = 6'h04;
    localparam logic [7:0] CFG0_WMASK = 8'h7e;
    localparam logic [1:0] MODE_FIXED = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCCM_CHOP_ZERO = 2'b00,
        ADCCM_CHOP_ONE  = 2'b01,
        ADCCM_CHOP_EACH = 2'b10,
        ADCCM_CHOP_PAIR = 2'b11
    } adccm_chop_t;

    typedef enum logic [0:0] {
        ADCCM_IDLE = 1'b0,
        ADCCM_CONV = 1'b1
    } adccm_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } adccm_req_t;

endpackage

// ---- verif/adccm_modulator_model.sv ----
// Modulator stand-in that answers each conversion with elementary-done pulses.
`timescale 1ns/100ps
module adccm_modulator_model
    import adccm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       convStart,
    input  wire logic       convBusy,
    input  wire logic [3:0] gap,
    output logic            elemDone
);
    // ------------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------------
    // The spacing input lets the bench answer promptly or slowly.
    logic [3:0] cnt_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 4'h0;
            elemDone <= 1'b0;
        end else begin
            elemDone <= convBusy && !convStart && (cnt_q == gap);
            cnt_q <= (convStart || cnt_q == gap || !convBusy) ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the converter configuration and mode registers.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
    import adccm_pkg::*;
    logic clk_sys, rstn, elemDone, supplyLow, first_stage_gain_select, referenceSel;
    logic convStart, convBusy, resultLoad, inputChop, refChop, pumpOn;
    logic reference_out_on_pin_a, external_reference_on_pin_b;
    logic [1:0] sample_rate_select, second_stage_gain_select, elementary_count_exponent;
    logic [3:0] second_stage_offset_select, gap;
    logic [6:0] third_stage_gain_select, third_stage_offset_select;
    logic [4:0] inputChannelSel;
    logic [7:0] regRdData, v, a, d;
    logic [31:0] seed = 32'h1d;
    adccm_req_t regReq;
    int n_fail, compares, ne, tg, ti;
    logic [7:0] ra [6] = '{8'h52, 8'h54, 8'h55, 8'h56, 8'h57, 8'h70};
    logic [7:0] rv [6] = '{8'h28, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h04};
    adccm_regs u_adccm_regs (.clk_sys(clk_sys), .rstn(rstn), .regReq(regReq), .regRdData(regRdData),
        .elemDone(elemDone), .supplyLow(supplyLow), .sample_rate_select(sample_rate_select),
        .second_stage_gain_select(second_stage_gain_select), .second_stage_offset_select(second_stage_offset_select),
        .first_stage_gain_select(first_stage_gain_select), .third_stage_gain_select(third_stage_gain_select),
        .third_stage_offset_select(third_stage_offset_select), .inputChannelSel(inputChannelSel),
        .referenceSel(referenceSel), .elementary_count_exponent(elementary_count_exponent),
        .convStart(convStart), .convBusy(convBusy), .resultLoad(resultLoad), .inputChop(inputChop),
        .refChop(refChop), .pumpOn(pumpOn), .reference_out_on_pin_a(reference_out_on_pin_a),
        .external_reference_on_pin_b(external_reference_on_pin_b));
    adccm_modulator_model u_adccm_modulator_model (.clk_sys(clk_sys), .rstn(rstn), .convStart(convStart),
        .convBusy(convBusy), .gap(gap), .elemDone(elemDone));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] expRd(input logic [7:0] ad, input logic [7:0] val);
        case (ad)
            OFS_CFG0: return {1'b0, val[6:1], 1'b0};
            OFS_MUX:  return {2'b00, val[5:0]};
            OFS_MODE: return {MODE_FIXED, val[5:0]};
            8'h54, 8'h55, 8'h56: return val;
            default:  return 8'h00;
        endcase
    endfunction
    task automatic tick();
        @(posedge clk_sys);
        #2;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        regReq = '{1'b1, 1'b0, ad, dt};
        @(posedge clk_sys);
        regReq <= '0;
        #2;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        regReq = '{1'b0, 1'b1, ad, 8'h00};
        tick();
        regReq.rd = 1'b0;
        tick();
        dt = regRdData;
    endtask
    task automatic finish_test();
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chkRst(input int n);
        for (int k = 0; k < n; k++) begin
            rd(ra[k], v);
            `CHK("resetValue", expRd(ra[k], rv[k]), v)
        end
    endtask
    // Starts a conversion, counts elementary pulses and reference chop toggles.
    task automatic runConv(input logic [7:0] ad, input logic [7:0] dt);
        logic prevChop;
        logic prevIn;
        int i;
        wr(ad, dt);
        `CHK("convStart", 1'b1, convStart)
        ne = 0;
        tg = 0;
        ti = 0;
        prevChop = refChop;
        prevIn = inputChop;
        for (i = 0; i < 300 && resultLoad !== 1'b1; i++) begin
            `CHK("busyRun", 1'b1, convBusy)
            ne += (elemDone === 1'b1);
            tick();
            tg += (refChop !== prevChop);
            prevChop = refChop;
            ti += (inputChop !== prevIn);
            prevIn = inputChop;
        end
        if (i == 300) begin
            n_fail++;
            finish_test();
        end
        `CHK("busyEnd", 1'b0, convBusy)
        `CHK("inChopToggles", ne, ti)
    endtask
    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        rstn = 1'b0;
        regReq = '0;
        supplyLow = 1'b0;
        gap = 4'h3;
        n_fail = 0;
        compares = 0;
        repeat (10) @(posedge clk_sys);
        #2 rstn = 1'b1;
        tick();
        chkRst(6);
        `CHK("pumpReset", 1'b0, pumpOn)
        wr(8'h60, rnd());
        rd(8'h60, v);
        `CHK("unmapped", 8'h00, v)
        for (int n = 0; n < 30; n++) begin
            a = ra[1 + rnd() % 5];
            d = rnd();
            if (a == OFS_MUX) d[6] = 1'b0;
            wr(a, d);
            case (a)
                OFS_RATE: `CHK("rateOut", d, {sample_rate_select, second_stage_gain_select, second_stage_offset_select})
                OFS_GAIN: `CHK("gainOut", d, {first_stage_gain_select, third_stage_gain_select})
                OFS_OFF3: `CHK("offOut", d[6:0], third_stage_offset_select)
                OFS_MUX:  `CHK("muxOut", d[5:0], {inputChannelSel, referenceSel})
                default:  `CHK("pinOut", d[1:0], {reference_out_on_pin_a, external_reference_on_pin_b})
            endcase
            rd(a, v);
            `CHK("readBack", expRd(a, d), v)
        end
        for (int i = 0; i < 8; i++) begin
            supplyLow = i[0];
            wr(OFS_MODE, {4'h0, i[2], i[1], 2'b00});
            repeat (4) tick();
            `CHK("pumpOn", i[2] | (!i[1] & i[0]), pumpOn)
        end
        for (int m = 0; m < 4; m++) begin
            wr(OFS_MODE, {2'b00, m[1:0], 4'h4});
            tick();
            if (m < 2) `CHK("chopHold", m[0], refChop)
            gap = (m == 1) ? 4'h9 : 4'h3;
            runConv(OFS_CFG0, 8'hc0);
            `CHK("elemCount", 4, ne)
            `CHK("expOut", 2'b10, elementary_count_exponent)
            `CHK("chopToggles", (m == 2) ? 4 : (m == 3) ? 2 : 0, tg)
        end
        wr(OFS_GAIN, 8'h00);
        wr(OFS_MUX, 8'h3f);
        runConv(OFS_MUX, 8'h40);
        `CHK("defElemCount", 2, ne)
        `CHK("defExpOut", 2'b01, elementary_count_exponent)
        chkRst(5);
        finish_test();
    end
endmodule
